// >>> adc_ctrl_pkg.sv
`default_nettype none
package adc_ctrl_pkg;
  // ----------------------------------------
  // register map and field layout
  // ----------------------------------------
  localparam logic [1:0] ADDR_CONTROL      = 2'h0;
  localparam logic [1:0] ADDR_PATTERN_HIGH = 2'h1;
  localparam logic [1:0] ADDR_PATTERN_LOW  = 2'h2;
  localparam logic [7:0] CONTROL_RESET     = 8'h08;
  localparam logic [5:0] PATTERN_RESET     = 6'h00;
  localparam logic [1:0] RSV_ZERO          = 2'h0;
  localparam int MODE_MSB   = 7;
  localparam int MODE_LSB   = 6;
  localparam int LANE_BIT   = 5;
  localparam int DCS_BIT    = 4;
  localparam int FORMAT_BIT = 3;
  localparam int ALIGN_BIT  = 2;
  localparam int PD_A_BIT   = 1;
  localparam int PD_B_BIT   = 0;
  localparam int PAT_HIGH_MSB = 5;
  localparam int PAT_HIGH_LSB = 0;
  localparam int PAT_LOW_MSB  = 7;
  localparam int PAT_LOW_LSB  = 2;
  typedef enum logic [1:0] {
    MODE_NORMAL   = 2'h0,
    MODE_FIXED    = 2'h1,
    MODE_USER     = 2'h2,
    MODE_RESERVED = 2'h3
  } op_mode_t;
  localparam logic [11:0] FIXED_PATTERN = 12'hA63;
  // ----------------------------------------
  // serial access framing
  // ----------------------------------------
  localparam logic [4:0] ACCESS_BITS = 5'h10;
  localparam logic [4:0] HEADER_BITS = 5'h08;
  localparam int         RW_POS      = 6;
  typedef enum logic [2:0] {
    ACC_IDLE  = 3'b001,
    ACC_SHIFT = 3'b010,
    ACC_DONE  = 3'b100
  } access_state_t;
  // ----------------------------------------
  // output word timing, one bit per clock
  // ----------------------------------------
  localparam logic [3:0] WORD_LAST     = 4'hB;
  localparam logic [3:0] HALF_LAST     = 4'h5;
  localparam logic [3:0] STAGGER_POINT = 4'h2;
endpackage
`default_nettype wire

// >>> reg_access_if.sv
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
  logic       wr;
  logic [1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport engine (output wr, output addr, output wdata, input rdata);
  modport bank   (input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// >>> serial_access_engine.sv
`timescale 1ns/1ps
`default_nettype none
module serial_access_engine import adc_ctrl_pkg::*; (
  // clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_resetn,
  // synchronised serial pins
  input  wire logic   i_enable,
  input  wire logic   i_select_n,
  input  wire logic   i_sclk,
  input  wire logic   i_sclk_prev,
  input  wire logic   i_sdi,
  output logic        o_sdo,
  output logic        o_sdo_oe,
  // register side
  reg_access_if.engine bus
);
  access_state_t state;
  logic [4:0]    count;
  logic [7:0]    shift;
  logic          rw;
  logic          sclk_rise;
  logic          sclk_fall;

  assign sclk_rise = i_sclk && !i_sclk_prev;
  assign sclk_fall = !i_sclk && i_sclk_prev;
  assign bus.wdata = shift;

  // ----------------------------------------
  // access sequencing
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !i_enable) begin
      state <= ACC_IDLE;
    end else begin
      case (state)
        ACC_IDLE:  if (!i_select_n) state <= ACC_SHIFT;
        ACC_SHIFT: begin
          // early deselect drops the access with no write
          if (i_select_n) state <= ACC_IDLE;
          else if (sclk_rise && count == ACCESS_BITS - 5'h01) state <= ACC_DONE;
        end
        ACC_DONE:  if (i_select_n) state <= ACC_IDLE;
        default:   state <= ACC_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn || state == ACC_IDLE) begin
      count <= 5'h00;
    end else if (state == ACC_SHIFT && sclk_rise) begin
      count <= count + 5'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      shift    <= 8'h00;
      rw       <= 1'b0;
      bus.addr <= ADDR_CONTROL;
    end else if (state == ACC_SHIFT && sclk_rise) begin
      shift <= {shift[6:0], i_sdi};
      if (count == HEADER_BITS - 5'h01) begin
        rw       <= shift[RW_POS];
        bus.addr <= {shift[0], i_sdi};
      end
    end
  end

  // write only on deselect after all sixteen clocks, never for a read
  always_ff @(posedge i_clk) begin
    if (!i_resetn) bus.wr <= 1'b0;
    else bus.wr <= i_enable && state == ACC_DONE && i_select_n && !rw;
  end

  // ----------------------------------------
  // read data, msb first on second byte
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_sdo    <= 1'b0;
      o_sdo_oe <= 1'b0;
    end else begin
      o_sdo_oe <= i_enable && !i_select_n;
      if (state == ACC_IDLE) o_sdo <= 1'b0;
      else if (state == ACC_SHIFT && sclk_fall && count[3])
        o_sdo <= bus.rdata[~count[2:0]];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_write_full_access;
    @(posedge i_clk) disable iff (!i_resetn)
      bus.wr |-> $past(state) == ACC_DONE && $past(count) == ACCESS_BITS && !$past(rw);
  endproperty
  a_write_full_access: assert property (p_write_full_access)
    else $error("write without complete access");

  property p_no_write_disabled;
    @(posedge i_clk) disable iff (!i_resetn)
      !$past(i_enable) |-> !bus.wr && !o_sdo_oe;
  endproperty
  a_no_write_disabled: assert property (p_no_write_disabled)
    else $error("serial activity while disabled");

  c_write: cover property (@(posedge i_clk) disable iff (!i_resetn) bus.wr);
  c_read:  cover property (@(posedge i_clk) disable iff (!i_resetn)
    state == ACC_DONE && rw && i_select_n);
endmodule
`default_nettype wire

// >>> adc_control_register_bank.sv
// Function
// - mode 00 outputs converted samples
// - mode 01 outputs fixed pattern
// - mode 10 outputs user pattern
// - lane bit 0 splits word over lanes
// - lane bit 1: second lane, first Hi-Z
// - bit 4 drives duty stabilizer enable
// - bit 3 selects twos complement coding
// - alignment 0 staggers lanes half word
// - alignment 1 delays second lane one cycle
// - bit 1 powers down channel A
// - bit 0 powers down channel B
// - address 1 bits 5:0 pattern high
// - address 2 bits 7:2 pattern low
// - registers govern only while serial enabled
// - write on deselect after sixteen clocks
// - read/write bit: 1 read, 0 write
`timescale 1ns/1ps
`default_nettype none
module adc_control_register_bank import adc_ctrl_pkg::*; (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // serial control pins
  input  wire logic        i_serial_enable,
  input  wire logic        i_serial_select_n,
  input  wire logic        i_sclk,
  input  wire logic        i_sdi,
  output logic             o_sdo,
  output logic             o_sdo_oe,
  // direct control pins
  input  wire logic        i_pin_test,
  input  wire logic        i_pin_lane_config,
  input  wire logic        i_pin_word_align,
  input  wire logic        i_pin_format_dcs,
  input  wire logic        i_pin_powerdown_a,
  input  wire logic        i_pin_powerdown_b,
  // converted samples
  input  wire logic [11:0] i_sample_a,
  input  wire logic [11:0] i_sample_b,
  // serial data lanes, index 0 channel A, 1 channel B
  output logic [1:0]       o_first_serial_lane,
  output logic [1:0]       o_first_serial_lane_oe,
  output logic [1:0]       o_second_serial_lane,
  output logic             o_word_start,
  // settings to analog
  output logic             o_duty_stabilizer_enable,
  output logic             o_number_format_select,
  output logic             o_channel_a_powerdown,
  output logic             o_channel_b_powerdown
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [9:0]  pin_meta;
  logic [9:0]  pin_sync;
  logic        sclk_prev;
  logic        serial_en;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      // select resets to its idle high level, so no false access follows reset
      pin_meta  <= 10'h100;
      pin_sync  <= 10'h100;
      sclk_prev <= 1'b0;
    end else begin
      pin_meta  <= {i_serial_enable, i_serial_select_n, i_sclk, i_sdi, i_pin_test,
                    i_pin_lane_config, i_pin_word_align, i_pin_format_dcs,
                    i_pin_powerdown_a, i_pin_powerdown_b};
      pin_sync  <= pin_meta;
      sclk_prev <= pin_sync[7];
    end
  end
  assign serial_en = pin_sync[9];

  reg_access_if acc ();

  serial_access_engine u_engine (
    .i_clk      (i_clk),
    .i_resetn   (i_resetn),
    .i_enable   (serial_en),
    .i_select_n (pin_sync[8]),
    .i_sclk     (pin_sync[7]),
    .i_sclk_prev(sclk_prev),
    .i_sdi      (pin_sync[6]),
    .o_sdo      (o_sdo),
    .o_sdo_oe   (o_sdo_oe),
    .bus        (acc.engine)
  );

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [7:0]  control;
  logic [5:0]  pattern_high;
  logic [5:0]  pattern_low;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      control      <= CONTROL_RESET;
      pattern_high <= PATTERN_RESET;
      pattern_low  <= PATTERN_RESET;
    end else if (acc.wr) begin
      case (acc.addr)
        ADDR_CONTROL:      control <= acc.wdata;
        ADDR_PATTERN_HIGH: pattern_high <= acc.wdata[PAT_HIGH_MSB:PAT_HIGH_LSB];
        ADDR_PATTERN_LOW:  pattern_low <= acc.wdata[PAT_LOW_MSB:PAT_LOW_LSB];
        default: ;
      endcase
    end
  end

  // reserved bits are not stored and read back as zero
  always_comb begin
    case (acc.addr)
      ADDR_CONTROL:      acc.rdata = control;
      ADDR_PATTERN_HIGH: acc.rdata = {RSV_ZERO, pattern_high};
      ADDR_PATTERN_LOW:  acc.rdata = {pattern_low, RSV_ZERO};
      default:           acc.rdata = 8'h00;
    endcase
  end

  // ----------------------------------------
  // effective settings
  // ----------------------------------------
  logic [7:0]  next_cfg;
  always_comb begin
    if (serial_en) begin
      next_cfg = control;
    end else begin
      next_cfg = {(pin_sync[5] ? MODE_FIXED : MODE_NORMAL), pin_sync[4], pin_sync[2],
                  pin_sync[2], pin_sync[3], pin_sync[1], pin_sync[0]};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_duty_stabilizer_enable <= CONTROL_RESET[DCS_BIT];
      o_number_format_select   <= CONTROL_RESET[FORMAT_BIT];
      o_channel_a_powerdown    <= CONTROL_RESET[PD_A_BIT];
      o_channel_b_powerdown    <= CONTROL_RESET[PD_B_BIT];
    end else begin
      o_duty_stabilizer_enable <= next_cfg[DCS_BIT];
      o_number_format_select   <= next_cfg[FORMAT_BIT];
      o_channel_a_powerdown    <= next_cfg[PD_A_BIT];
      o_channel_b_powerdown    <= next_cfg[PD_B_BIT];
    end
  end

  // ----------------------------------------
  // word source selection
  // ----------------------------------------
  function automatic logic [11:0] word_for(input logic [7:0] cfg, input logic [11:0] smp,
                                           input logic pd, input logic [11:0] pat);
    case (op_mode_t'(cfg[MODE_MSB:MODE_LSB]))
      MODE_FIXED: word_for = FIXED_PATTERN;
      MODE_USER:  word_for = pat;
      // reserved code is not expected; treated as normal
      default:    word_for = pd ? 12'h000 : (cfg[FORMAT_BIT] ? {~smp[11], smp[10:0]} : smp);
    endcase
  endfunction

  // ----------------------------------------
  // output word serialiser
  // ----------------------------------------
  logic [7:0]  active_cfg;
  logic [3:0]  bit_cnt;
  logic        word_end;
  logic        dual;
  logic [11:0] sample [2];
  logic [1:0]  pd_vec;
  logic [11:0] held_word [2];
  logic [11:0] lane1_shift [2];
  logic [5:0]  lane0_shift [2];
  logic [1:0]  lane1_dly;

  assign sample[0] = i_sample_a;
  assign sample[1] = i_sample_b;
  assign pd_vec    = {next_cfg[PD_B_BIT], next_cfg[PD_A_BIT]};

  logic [11:0] next_word [2];
  always_comb begin
    for (int ch = 0; ch < 2; ch++)
      next_word[ch] = word_for(next_cfg, sample[ch], pd_vec[ch], {pattern_high, pattern_low});
  end
  assign dual      = !active_cfg[LANE_BIT];
  assign word_end  = bit_cnt == (dual ? HALF_LAST : WORD_LAST);

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      active_cfg   <= CONTROL_RESET;
      bit_cnt      <= 4'h0;
      o_word_start <= 1'b0;
    end else begin
      o_word_start <= word_end;
      bit_cnt      <= word_end ? 4'h0 : bit_cnt + 4'h1;
      if (word_end) active_cfg <= next_cfg;
    end
  end

  always_ff @(posedge i_clk) begin
    for (int ch = 0; ch < 2; ch++) begin
      if (!i_resetn) begin
        held_word[ch]   <= 12'h000;
        lane1_shift[ch] <= 12'h000;
        lane0_shift[ch] <= 6'h00;
        lane1_dly[ch]   <= 1'b0;
      end else begin
        lane1_dly[ch] <= lane1_shift[ch][11];
        if (word_end) begin
          // both channels take the test pattern in a test mode
          held_word[ch]   <= next_word[ch];
          lane1_shift[ch] <= next_cfg[LANE_BIT] ? next_word[ch] :
                             {next_word[ch][11:6], 6'h00};
        end else begin
          lane1_shift[ch] <= {lane1_shift[ch][10:0], 1'b0};
        end
        // first lane starts mid-word unless aligned
        if (dual && (active_cfg[ALIGN_BIT] ? bit_cnt == HALF_LAST : bit_cnt == STAGGER_POINT))
          lane0_shift[ch] <= active_cfg[ALIGN_BIT] ? next_word[ch][5:0] :
                             held_word[ch][5:0];
        else
          lane0_shift[ch] <= {lane0_shift[ch][4:0], 1'b0};
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_first_serial_lane    <= 2'h0;
      o_first_serial_lane_oe <= 2'h0;
      o_second_serial_lane   <= 2'h0;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        o_first_serial_lane[ch]    <= dual && lane0_shift[ch][5];
        o_first_serial_lane_oe[ch] <= dual;
        o_second_serial_lane[ch]   <= (dual && active_cfg[ALIGN_BIT]) ?
                                      lane1_dly[ch] : lane1_shift[ch][11];
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_fixed;
    word_end && next_cfg[MODE_MSB:MODE_LSB] == MODE_FIXED |=>
      held_word[0] == FIXED_PATTERN && held_word[1] == FIXED_PATTERN;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed pattern missing");

  property p_user;
    word_end && next_cfg[MODE_MSB:MODE_LSB] == MODE_USER |=>
      held_word[0] == {$past(pattern_high), $past(pattern_low)} && held_word[1] == held_word[0];
  endproperty
  a_user: assert property (p_user) else $error("user pattern wrong");

  property p_twos;
    word_end && next_cfg[MODE_MSB:MODE_LSB] == MODE_NORMAL && !next_cfg[PD_A_BIT] |=>
      held_word[0] == ($past(next_cfg[FORMAT_BIT]) ?
                       {~$past(i_sample_a[11]), $past(i_sample_a[10:0])} : $past(i_sample_a));
  endproperty
  a_twos: assert property (p_twos) else $error("sample coding wrong");

  property p_pd_a;
    word_end && next_cfg[MODE_MSB:MODE_LSB] == MODE_NORMAL && next_cfg[PD_A_BIT] |=>
      held_word[0] == 12'h000;
  endproperty
  a_pd_a: assert property (p_pd_a) else $error("channel A not suspended");

  property p_pd_b;
    word_end && next_cfg[MODE_MSB:MODE_LSB] == MODE_NORMAL && next_cfg[PD_B_BIT] |=>
      held_word[1] == 12'h000;
  endproperty
  a_pd_b: assert property (p_pd_b) else $error("channel B not suspended");

  property p_hiz;
    !dual |=> o_first_serial_lane_oe == 2'h0;
  endproperty
  a_hiz: assert property (p_hiz) else $error("first lane driven in single lane");

  property p_align;
    dual && active_cfg[ALIGN_BIT] && $past(dual && active_cfg[ALIGN_BIT]) |=>
      o_second_serial_lane[0] == $past(lane1_shift[0][11], 2);
  endproperty
  a_align: assert property (p_align) else $error("aligned lane delay wrong");

  property p_stagger;
    dual && !active_cfg[ALIGN_BIT] && bit_cnt == STAGGER_POINT |=>
      lane0_shift[0] == $past(held_word[0][5:0]);
  endproperty
  a_stagger: assert property (p_stagger) else $error("half word stagger wrong");

  property p_hold_cfg;
    !word_end |=> active_cfg == $past(active_cfg);
  endproperty
  a_hold_cfg: assert property (p_hold_cfg) else $error("setting changed mid word");

  c_fixed_word: cover property (word_end && next_cfg[MODE_MSB:MODE_LSB] == MODE_FIXED);
  c_user_word:  cover property (word_end && next_cfg[MODE_MSB:MODE_LSB] == MODE_USER);
  c_aligned:    cover property (dual && active_cfg[ALIGN_BIT] && word_end);
endmodule
`default_nettype wire

// >>> host_serial_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_serial_model #(
  parameter int PH = 6
) (
  // clock
  input  wire logic i_clk,
  // serial pins
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe,
  output logic      o_select_n,
  output logic      o_sclk,
  output logic      o_sdi
);
  logic oe_seen;

  initial begin
    o_select_n = 1'b1;
    o_sclk     = 1'b0;
    o_sdi      = 1'b0;
    oe_seen    = 1'b0;
  end

  // ----------------------------------------
  // one access, msb first
  // ----------------------------------------
  // nbits below 16 cuts the access short on purpose
  task automatic xfer(input logic [15:0] w, input int nbits, output logic [7:0] rd);
    rd      = 8'h00;
    oe_seen = 1'b0;
    @(negedge i_clk);
    o_select_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      o_sdi = w[15 - i];
      repeat (PH) @(negedge i_clk);
      oe_seen = oe_seen | i_sdo_oe;
      if (i >= 8) rd = {rd[6:0], i_sdo};
      o_sclk = 1'b1;
      repeat (PH) @(negedge i_clk);
      o_sclk = 1'b0;
    end
    repeat (PH) @(negedge i_clk);
    // released line shows the inverse, not a stale bit
    o_sdi      = ~o_sdi;
    o_select_n = 1'b1;
    repeat (PH) @(negedge i_clk);
  endtask
endmodule
`default_nettype wire

// >>> adc_control_register_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_control_register_bank_tb;
  logic        i_clk;
  logic        i_resetn;
  logic        i_serial_enable;
  logic        select_n;
  logic        sclk;
  logic        sdi;
  logic        o_sdo;
  logic        o_sdo_oe;
  logic [5:0]  pins;
  logic [11:0] i_sample_a;
  logic [11:0] i_sample_b;
  logic [1:0]  o_first_serial_lane;
  logic [1:0]  o_first_serial_lane_oe;
  logic [1:0]  o_second_serial_lane;
  logic        o_word_start;
  logic [3:0]  knobs;
  logic [23:0] s_a2;
  logic [23:0] s_b2;
  logic [23:0] s_a1;
  logic [7:0]  r;
  int          fails;
  int          n_checks;

  adc_control_register_bank dut (
    .i_clk                    (i_clk),
    .i_resetn                 (i_resetn),
    .i_serial_enable          (i_serial_enable),
    .i_serial_select_n        (select_n),
    .i_sclk                   (sclk),
    .i_sdi                    (sdi),
    .o_sdo                    (o_sdo),
    .o_sdo_oe                 (o_sdo_oe),
    .i_pin_test               (pins[5]),
    .i_pin_lane_config        (pins[4]),
    .i_pin_word_align         (pins[3]),
    .i_pin_format_dcs         (pins[2]),
    .i_pin_powerdown_a        (pins[1]),
    .i_pin_powerdown_b        (pins[0]),
    .i_sample_a               (i_sample_a),
    .i_sample_b               (i_sample_b),
    .o_first_serial_lane      (o_first_serial_lane),
    .o_first_serial_lane_oe   (o_first_serial_lane_oe),
    .o_second_serial_lane     (o_second_serial_lane),
    .o_word_start             (o_word_start),
    .o_duty_stabilizer_enable (knobs[3]),
    .o_number_format_select   (knobs[2]),
    .o_channel_a_powerdown    (knobs[1]),
    .o_channel_b_powerdown    (knobs[0])
  );

  host_serial_model host (
    .i_clk      (i_clk),
    .i_sdo      (o_sdo),
    .i_sdo_oe   (o_sdo_oe),
    .o_select_n (select_n),
    .o_sclk     (sclk),
    .o_sdi      (sdi)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    host.xfer({1'b0, 5'h00, a, d}, 16, r);
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    host.xfer({1'b1, 5'h00, a, 8'h00}, 16, r);
    chk(12'(r), 12'(exp));
  endtask

  // skips one boundary so the new setting is surely in force
  task automatic grab();
    int n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(negedge i_clk);
        n++;
      end while (o_word_start !== 1'b1 && n < 40);
    end
    for (int i = 0; i < 24; i++) begin
      s_a2 = {s_a2[22:0], o_second_serial_lane[0]};
      s_b2 = {s_b2[22:0], o_second_serial_lane[1]};
      s_a1 = {s_a1[22:0], o_first_serial_lane[0]};
      @(negedge i_clk);
    end
  endtask

  // word start may lead the first bit by one cycle
  function automatic logic [11:0] hit(input logic [23:0] s, input logic [11:0] w);
    return 12'((s[23:12] === w) || (s[22:11] === w));
  endfunction

  function automatic logic [11:0] off6(input logic [23:0] s, input logic [5:0] w);
    for (int k = 0; k < 12; k++)
      if (s[23 - k -: 6] === w) return 12'(k);
    return 12'hF;
  endfunction

  // first lane position behind second lane, fixed pattern halves
  function automatic logic [11:0] lag();
    return (off6(s_a1, 6'h23) + 12'h6 - off6(s_a2, 6'h29)) % 12'h6;
  endfunction

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  initial begin
    repeat (40000) @(posedge i_clk);
    fails++;
    tally_and_finish();
  end

  initial begin
    fails           = 0;
    n_checks        = 0;
    i_resetn        = 1'b0;
    i_serial_enable = 1'b1;
    pins            = 6'h00;
    i_sample_a      = 12'h5A5;
    i_sample_b      = 12'h3C3;
    repeat (2) @(negedge i_clk);
    i_resetn = 1'b1;
    repeat (4) @(negedge i_clk);
    chk(12'(knobs), 12'h4);
    rd(2'h0, 8'h08);
    chk(12'(host.oe_seen), 12'h1);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h00);
    done("reset");
    wr(2'h0, 8'h17);
    repeat (2) @(negedge i_clk);
    chk(12'(knobs), 12'hB);
    rd(2'h0, 8'h17);
    wr(2'h0, 8'h08);
    repeat (2) @(negedge i_clk);
    chk(12'(knobs), 12'h4);
    done("control fields");
    wr(2'h1, 8'hFF);
    rd(2'h1, 8'h3F);
    wr(2'h2, 8'hFF);
    rd(2'h2, 8'hFC);
    wr(2'h3, 8'h5A);
    rd(2'h3, 8'h00);
    rd(2'h0, 8'h08);
    done("patterns");
    host.xfer(16'h0055, 15, r);
    rd(2'h0, 8'h08);
    host.xfer(16'h8055, 16, r);
    rd(2'h0, 8'h08);
    i_serial_enable = 1'b0;
    pins            = 6'h05;
    wr(2'h0, 8'h17);
    chk(12'(host.oe_seen), 12'h0);
    repeat (8) @(negedge i_clk);
    chk(12'(knobs), 12'hD);
    i_serial_enable = 1'b1;
    pins            = 6'h00;
    repeat (8) @(negedge i_clk);
    rd(2'h0, 8'h08);
    chk(12'(knobs), 12'h4);
    done("refusals");
    wr(2'h0, 8'h60);
    grab();
    chk(hit(s_b2, 12'hA63), 12'h1);
    chk(hit(s_a2, 12'hA63), 12'h1);
    chk(12'(o_first_serial_lane_oe), 12'h0);
    wr(2'h1, 8'h2D);
    wr(2'h2, 8'h5C);
    wr(2'h0, 8'hA0);
    grab();
    chk(hit(s_a2, 12'hB57), 12'h1);
    chk(hit(s_b2, 12'hB57), 12'h1);
    done("test patterns");
    wr(2'h0, 8'h40);
    grab();
    chk(12'(o_first_serial_lane_oe), 12'h3);
    chk(lag(), 12'h3);
    wr(2'h0, 8'h44);
    grab();
    chk(lag(), 12'h5);
    done("dual lane");
    wr(2'h0, 8'h20);
    grab();
    chk(hit(s_a2, 12'h5A5), 12'h1);
    chk(hit(s_b2, 12'h3C3), 12'h1);
    wr(2'h0, 8'h28);
    grab();
    chk(hit(s_a2, 12'hDA5), 12'h1);
    wr(2'h0, 8'h2A);
    grab();
    chk(hit(s_a2, 12'h000), 12'h1);
    chk(hit(s_b2, 12'hBC3), 12'h1);
    wr(2'h0, 8'h21);
    grab();
    chk(hit(s_a2, 12'h5A5), 12'h1);
    chk(hit(s_b2, 12'h000), 12'h1);
    done("normal output");
    tally_and_finish();
  end
endmodule
`default_nettype wire
